// [rtl/pce_pkg.sv]
// How it works
// - port b pins 7..4: enabled falling edge sets pin flag and shared flag
// - port b flag sets on enabled rising edge or on enabled falling edge
// - pin change flags stay set until software writes zero to them; the shared flag stays set until software writes one to it
// - port b bits 3..0 of enable and flag registers read zero, ignore writes
// - port c pins 7..0: enabled rising edge sets pin flag and shared flag
// - every enable and flag bit clears to zero on any reset
// - port b pins 7..4: enabled rising edge sets pin flag and shared flag
package pce_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] PCE_OFS_PB_RISE   = 8'h00;
  localparam logic [7:0] PCE_OFS_PB_FALL   = 8'h04;
  localparam logic [7:0] PCE_OFS_PB_FLAG   = 8'h08;
  localparam logic [7:0] PCE_OFS_PC_RISE   = 8'h0C;
  localparam logic [7:0] PCE_OFS_PC_FLAG   = 8'h10;
  localparam logic [7:0] PCE_OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0] PCE_OFS_IRQ_MASK  = 8'h18;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam logic [7:0] PCE_PB_IMPL_MASK  = 8'hF0;
  localparam logic [7:0] PCE_PC_IMPL_MASK  = 8'hFF;
  localparam int         PCE_STAT_SHARED   = 0;
  localparam logic [7:0] PCE_REG_RST       = 8'h00;
  localparam logic [1:0] PCE_PRIME_DONE    = 2'h3;

  // ****************************************
  // apb answer
  // ****************************************
  localparam logic [31:0] PCE_RDATA_UNMAPPED = 32'h0000_0000;

endpackage : pce_pkg

// [rtl/pce_pin_sync.sv]
`timescale 1ns/100ps
module pce_pin_sync (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // pins from outside the clock domain
  input  wire logic [7:0] pin_async,
  // one-cycle edge pulses
  output logic      [7:0] rise,
  output logic      [7:0] fall
);
  import pce_pkg::*;

  typedef struct packed {
    logic [7:0] meta;
    logic [7:0] sync;
    logic [7:0] prev;
    logic [1:0] prime;
  } pce_sync_st_t;

  pce_sync_st_t s_q;
  pce_sync_st_t s_d;

  // two-flop synchroniser then one sample of history
  always_comb begin
    s_d      = s_q;
    s_d.meta = pin_async;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    if (s_q.prime != PCE_PRIME_DONE) begin
      s_d.prime = s_q.prime + 2'h1;
    end
  end

  // history is not trusted until the chain has filled, so a pin
  // that is already high at reset does not look like an edge
  always_comb begin
    rise = '0;
    fall = '0;
    if (s_q.prime == PCE_PRIME_DONE) begin
      rise = s_q.sync & ~s_q.prev;
      fall = ~s_q.sync & s_q.prev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : pce_pin_sync

// [rtl/pce_edge_detect.sv]
`timescale 1ns/100ps
module pce_edge_detect (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  // pins
  input  wire logic [7:0]  portb_pin,
  input  wire logic [7:0]  portc_pin,
  // shared change flag and interrupt
  output logic             shared_change_irq_flag,
  output logic             irq
);
  import pce_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]  portb_rise_enable;
    logic [7:0]  portb_fall_enable;
    logic [7:0]  portb_change_flag;
    logic [7:0]  portc_rise_enable;
    logic [7:0]  portc_change_flag;
    logic        stat_shared;
    logic        mask_shared;
    logic [31:0] rdata;
  } pce_state_t;

  pce_state_t st_q;
  pce_state_t st_d;

  // ****************************************
  // internal signals
  // ****************************************
  // raw one-cycle edge pulses from the synchronisers
  logic [7:0] pb_rise;
  logic [7:0] pb_fall;
  logic [7:0] pc_rise;
  // edges that reach a flag this cycle
  logic [7:0] pb_set;
  logic [7:0] pc_set;
  logic       any_set;
  logic       wr_en;
  logic       setup_rd;
  logic       acc_phase;
  logic       pb_any;
  logic       pc_any;
  logic       stat_clr;
  logic [31:0] rd_word;
  // per-source qualified edges, kept apart so each enable can be seen alone
  logic [7:0] pb_rise_hit;
  logic [7:0] pb_fall_hit;
  logic [7:0] pc_rise_hit;
  // one strobe per register, decoded once for the whole access phase
  logic       wr_pb_rise;
  logic       wr_pb_fall;
  logic       wr_pb_flag;
  logic       wr_pc_rise;
  logic       wr_pc_flag;
  logic       wr_stat;
  logic       wr_mask;
  // write data as each register width sees it
  logic [7:0] wr_byte;
  logic       wr_one;

  // ****************************************
  // pin synchronisers
  // ****************************************
  pce_pin_sync u_sync_b (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (portb_pin),
    .rise      (pb_rise),
    .fall      (pb_fall)
  );

  // falling edges of port c are handled by a sibling block
  pce_pin_sync u_sync_c (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (portc_pin),
    .rise      (pc_rise),
    .fall      ()
  );

  // ****************************************
  // address decode
  // ****************************************
  // only the seven word addresses of the map answer without an error;
  // anything else, misaligned words included, is refused
  function automatic logic pce_mapped(input logic [7:0] a);
    case (a)
      PCE_OFS_PB_RISE,
      PCE_OFS_PB_FALL,
      PCE_OFS_PB_FLAG:  pce_mapped = 1'b1;
      PCE_OFS_PC_RISE,
      PCE_OFS_PC_FLAG:  pce_mapped = 1'b1;
      PCE_OFS_IRQ_STAT,
      PCE_OFS_IRQ_MASK: pce_mapped = 1'b1;
      default:          pce_mapped = 1'b0;
    endcase
  endfunction : pce_mapped

  // zero-extend an eight-bit register to the bus width
  function automatic logic [31:0] pce_word8(input logic [7:0] v);
    pce_word8 = {24'h000000, v};
  endfunction : pce_word8

  // zero-extend a one-bit register to the bus width
  function automatic logic [31:0] pce_word1(input logic v);
    pce_word1 = {31'h0, v};
  endfunction : pce_word1

  function automatic logic [31:0] pce_read(input pce_state_t s, input logic [7:0] a);
    pce_read = PCE_RDATA_UNMAPPED;
    case (a)
      // port b: only the upper nibble exists, the rest reads zero
      PCE_OFS_PB_RISE:  pce_read = pce_word8(s.portb_rise_enable);
      PCE_OFS_PB_FALL:  pce_read = pce_word8(s.portb_fall_enable);
      PCE_OFS_PB_FLAG:  pce_read = pce_word8(s.portb_change_flag);
      // port c: all eight pins
      PCE_OFS_PC_RISE:  pce_read = pce_word8(s.portc_rise_enable);
      PCE_OFS_PC_FLAG:  pce_read = pce_word8(s.portc_change_flag);
      // shared bit and its mask
      PCE_OFS_IRQ_STAT: pce_read = pce_word1(s.stat_shared);
      PCE_OFS_IRQ_MASK: pce_read = pce_word1(s.mask_shared);
      default:          pce_read = PCE_RDATA_UNMAPPED;
    endcase
  endfunction : pce_read

  // true when the bus address selects the given register
  function automatic logic pce_hit(input logic [7:0] a, input logic [7:0] ofs);
    pce_hit = (a == ofs);
  endfunction : pce_hit

  // write byte with the unimplemented positions forced low
  function automatic logic [7:0] pce_byte(input logic [7:0] d, input logic [7:0] impl);
    pce_byte = d & impl;
  endfunction : pce_byte

  // next value of a flag register: a write replaces it, then the hardware
  // set of the same cycle is ORed in last so that the set always wins
  function automatic logic [7:0] pce_flag_next(input logic [7:0] cur, input logic wr,
                                               input logic [7:0] wval,
                                               input logic [7:0] set);
    logic [7:0] v;
    v = cur;
    if (wr) begin
      v = wval;
    end
    pce_flag_next = v | set;
  endfunction : pce_flag_next

  // sticky shared bit: a written one clears it, an edge in the same
  // cycle sets it again, so software never misses an event
  function automatic logic pce_stat_next(input logic cur, input logic clr, input logic set);
    pce_stat_next = (cur & ~clr) | set;
  endfunction : pce_stat_next

  // ****************************************
  // edge qualification
  // ****************************************
  // enables gate the raw edges; unimplemented low bits never fire,
  // whatever the pins below them do
  always_comb begin
    pb_rise_hit = pb_rise & st_q.portb_rise_enable & PCE_PB_IMPL_MASK;
    pb_fall_hit = pb_fall & st_q.portb_fall_enable & PCE_PB_IMPL_MASK;
  end

  // port c only watches rising edges here; its falling side lives elsewhere
  always_comb begin
    pc_rise_hit = pc_rise & st_q.portc_rise_enable & PCE_PC_IMPL_MASK;
  end

  // either enabled direction marks a port b pin as changed, and any
  // marked pin of either port raises the shared bit
  always_comb begin
    pb_set  = pb_rise_hit | pb_fall_hit;
    pc_set  = pc_rise_hit;
    pb_any  = |pb_set;
    pc_any  = |pc_set;
    any_set = pb_any | pc_any;
  end

  // ****************************************
  // apb handshake
  // ****************************************
  // zero wait states: read data is captured in the setup cycle, which
  // costs one flop stage but keeps paddr off the prdata timing path
  assign acc_phase = psel & penable;
  assign wr_en     = acc_phase & pwrite;
  assign setup_rd  = psel & ~penable;
  assign pready    = 1'b1;
  assign pslverr   = acc_phase & ~pce_mapped(paddr);
  assign prdata    = st_q.rdata;

  // ****************************************
  // write decode
  // ****************************************
  // strobes exist only in the access phase, which lasts one cycle
  // because pready is tied high in every cycle
  always_comb begin
    wr_pb_rise = wr_en & pce_hit(paddr, PCE_OFS_PB_RISE);
    wr_pb_fall = wr_en & pce_hit(paddr, PCE_OFS_PB_FALL);
    wr_pb_flag = wr_en & pce_hit(paddr, PCE_OFS_PB_FLAG);
    wr_pc_rise = wr_en & pce_hit(paddr, PCE_OFS_PC_RISE);
    wr_pc_flag = wr_en & pce_hit(paddr, PCE_OFS_PC_FLAG);
    wr_stat    = wr_en & pce_hit(paddr, PCE_OFS_IRQ_STAT);
    wr_mask    = wr_en & pce_hit(paddr, PCE_OFS_IRQ_MASK);
  end

  // only the low byte carries register bits; the upper bus bits are
  // ignored so wider software stores do no harm
  always_comb begin
    wr_byte = pwdata[7:0];
    wr_one  = pwdata[PCE_STAT_SHARED];
  end

  // a clearing write to the status word needs both the strobe and a one
  always_comb begin
    stat_clr = wr_stat & wr_one;
  end

  // ****************************************
  // read path
  // ****************************************
  // the word is picked from settled registers; unmapped addresses read
  // zero so a refused read never leaks old data
  always_comb begin
    rd_word = pce_read(st_q, paddr);
  end

  // ****************************************
  // register update
  // ****************************************
  // hardware set is ORed after the software write so a clearing
  // write never swallows an edge landing in the same cycle
  always_comb begin
    st_d = st_q;
    // enables: plain read/write, unimplemented bits stay zero
    if (wr_pb_rise) begin
      st_d.portb_rise_enable = pce_byte(wr_byte, PCE_PB_IMPL_MASK);
    end
    if (wr_pb_fall) begin
      st_d.portb_fall_enable = pce_byte(wr_byte, PCE_PB_IMPL_MASK);
    end
    if (wr_pc_rise) begin
      st_d.portc_rise_enable = pce_byte(wr_byte, PCE_PC_IMPL_MASK);
    end
    // flags: a written value stands until the next write, edges add to it
    st_d.portb_change_flag = pce_flag_next(st_q.portb_change_flag, wr_pb_flag,
                                           pce_byte(wr_byte, PCE_PB_IMPL_MASK),
                                           pb_set);
    st_d.portc_change_flag = pce_flag_next(st_q.portc_change_flag, wr_pc_flag,
                                           pce_byte(wr_byte, PCE_PC_IMPL_MASK),
                                           pc_set);
    // shared bit: write one to clear; the mask is a plain bit
    st_d.stat_shared = pce_stat_next(st_q.stat_shared, stat_clr, any_set);
    if (wr_mask) begin
      st_d.mask_shared = wr_one;
    end
    // the word stands in prdata from the end of setup to the next setup
    if (setup_rd) begin
      st_d.rdata = rd_word;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // all enables and flags to zero on any reset; the pins are not
  // looked at again until the synchronisers have refilled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // level interrupt: high while the sticky shared bit is set and
  // unmasked; it drops through a clearing write, a zero written to the mask, or a reset
  always_comb begin
    shared_change_irq_flag = st_q.stat_shared;
    irq                    = st_q.stat_shared & st_q.mask_shared;
  end

endmodule : pce_edge_detect

// [tb/pce_asserts.sv]
`timescale 1ns/100ps
module pce_asserts (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // pins and flags
  input wire logic [7:0]  portb_pin,
  input wire logic [7:0]  portc_pin,
  input wire logic        shared_change_irq_flag,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access-phase qualifiers
  wire rd  = psel && penable && !pwrite;
  wire clr = psel && penable && pwrite && paddr == 8'h14;
  wire [15:0] pins = {portb_pin, portc_pin};
  chk_flag_sticky: assert property (shared_change_irq_flag && !clr |=>
    shared_change_irq_flag) else $error("shared flag dropped");
  chk_flag_w1c: assert property ($fell(shared_change_irq_flag) |->
    $past(clr && pwdata[0])) else $error("shared flag fell without clear");
  chk_reset_clear: assert property (disable iff (1'b0) !presetn |=>
    !irq && !shared_change_irq_flag && prdata == 32'h0) else $error("reset state");
  chk_pb_low_zero: assert property (rd && paddr inside {8'h04, 8'h08} |->
    prdata[3:0] == 4'h0) else $error("port b low bits set");
  chk_pb_rise_zero: assert property (rd && paddr == 8'h00 |->
    prdata[3:0] == 4'h0) else $error("rise enable low bits set");
  chk_slverr_map: assert property (psel && penable && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > 8'h18)) else $error("error response wrong");
  chk_irq_flag: assert property (irq |-> shared_change_irq_flag)
    else $error("irq without flag");
  // a flag may only rise a few cycles after a pin really moved
  chk_edge_cause: assert property ($rose(shared_change_irq_flag) |->
    $past(pins, 2) != $past(pins, 7)) else $error("flag without pin edge");
  cover property ($rose(irq));
  cover property (clr && pwdata[0] && shared_change_irq_flag);
  cover property (psel && penable && pslverr);
endmodule : pce_asserts

bind pce_edge_detect pce_asserts u_pce_asserts (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pslverr, .prdata, .portb_pin, .portc_pin,
  .shared_change_irq_flag, .irq);

// [tb/pce_pin_model.sv]
`timescale 1ns/100ps
module pce_pin_model (
  // clock
  input  wire logic       pclk,
  // wanted levels
  input  wire logic [7:0] want_b,
  input  wire logic [7:0] want_c,
  // driven pins
  output logic      [7:0] portb_pin = 8'h00,
  output logic      [7:0] portc_pin = 8'h00
);
  // levels move once per cycle, so each stays stable long enough to be seen
  always @(posedge pclk) begin
    portb_pin <= want_b;
    portc_pin <= want_c;
  end
endmodule : pce_pin_model

// [tb/pce_edge_detect_bench.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module pce_edge_detect_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0]  paddr = 0, wb = 0, wc = 0, pb, pc, nb, nc, rb, fb, rc, eb, ec;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, sh_o, irq, sh, mk;
  int          errors = 0, n_checks = 0;
  always #5 pclk = ~pclk;
  pce_edge_detect u_pce_edge_detect (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .prdata, .portb_pin(pb), .portc_pin(pc),
    .shared_change_irq_flag(sh_o), .irq);
  pce_pin_model u_pce_pin_model (.pclk, .want_b(wb), .want_c(wc), .portb_pin(pb),
    .portc_pin(pc));
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // one apb transfer; waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      errors++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // bits of a pin word that saw an enabled edge
  function logic [7:0] edges(logic [7:0] o, n, r, f);
    return (~o & n & r) | (o & ~n & f);
  endfunction : edges
  // every register reads zero after any reset
  task reset_check;
    for (int a = 0; a <= 24; a += 4) begin
      apb(0, 8'(a), 0);
      `CHK(rd, 32'h0)
    end
  endtask : reset_check
  initial begin
    void'($urandom(64342));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    reset_check();
    apb(1, 8'h1C, 32'hFF);
    `CHK(er, 1'b1)
    apb(0, 8'h1C, 0);
    `CHK(rd, 32'h0)
    apb(1, 8'h00, 32'hFF);
    apb(1, 8'h04, 32'hFF);
    apb(1, 8'h0C, 32'hFF);
    apb(0, 8'h00, 0);
    `CHK(rd, 32'hF0)
    apb(0, 8'h04, 0);
    `CHK(rd, 32'hF0)
    apb(0, 8'h0C, 0);
    `CHK(rd, 32'hFF)
    rb = 8'hF0; fb = 8'hF0; rc = 8'hFF; eb = 0; ec = 0; sh = 0; mk = 0;
    for (int k = 0; k < 40; k++) begin
      if (k % 6 == 5) begin
        // clear everything, then fresh random enables and mask
        apb(1, 8'h08, 0);
        apb(1, 8'h10, 0);
        apb(1, 8'h14, 1);
        rb = 8'($urandom); fb = 8'($urandom); rc = 8'($urandom); mk = 1'($urandom);
        apb(1, 8'h00, {24'h0, rb});
        apb(1, 8'h04, {24'h0, fb});
        apb(1, 8'h0C, {24'h0, rc});
        apb(1, 8'h18, {31'h0, mk});
        rb &= 8'hF0; fb &= 8'hF0; eb = 0; ec = 0; sh = 0;
      end
      nb = 8'($urandom); nc = 8'($urandom);
      eb |= edges(wb, nb, rb, fb) & 8'hF0;
      ec |= edges(wc, nc, rc, 8'h00);
      sh = sh | (edges(wb, nb, rb, fb) & 8'hF0) != 0 | edges(wc, nc, rc, 8'h00) != 0;
      @(posedge pclk) wb <= nb;
      wc <= nc;
      // pin to flag takes 3 cycles plus one in the pin model
      repeat (6) @(posedge pclk);
      apb(0, 8'h08, 0);
      `CHK(rd, {24'h0, eb})
      apb(0, 8'h10, 0);
      `CHK(rd, {24'h0, ec})
      apb(0, 8'h14, 0);
      `CHK(rd, {31'h0, sh})
      `CHK(irq, sh & mk)
    end
    // corner: an enabled edge meets a clearing write in the same cycle
    apb(1, 8'h08, 0);
    apb(1, 8'h00, 32'hF0);
    apb(1, 8'h04, 32'hF0);
    nb = wb ^ 8'h80;
    @(posedge pclk) wb <= nb;
    @(posedge pclk);
    apb(1, 8'h08, 0);
    repeat (4) @(posedge pclk);
    apb(0, 8'h08, 0);
    `CHK(rd, 32'h80)
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    reset_check();
    `CHK(sh_o, 1'b0)
    give_verdict();
  end
endmodule : pce_edge_detect_bench
